// ### verification/aes256_ctr_pipeline_tb.sv
// Purpose: Self-checking bench for the counter-mode cipher pipeline
// Assumes: Public counter-mode test vectors; counter starts at 0 and steps 2 per word
// Notes: Counter wrap is not reachable in a short run
`timescale 1ns/10ps
`include "aes_ctr_params.svh"

module aes256_ctr_pipeline_tb
	import aes_ctr_pkg::*;
;
	localparam logic [`KEY_W-1:0] key1 = 256'h603DEB1015CA71BE2B73AEF0857D77811F352C073B6108D72D9810A30914DFF4;
	localparam logic [127:0] seed1 = 128'hF0F1F2F3F4F5F6F7F8F9FAFBFCFDFEFF;
	localparam logic [`WORD_W-1:0] ptA = {128'h6BC1BEE22E409F96E93D7E117393172A, 128'hAE2D8A571E03AC9C9EB76FAC45AF8E51};
	localparam logic [`WORD_W-1:0] ptB = {128'h30C81C46A35CE411E5FBC1191A0A52EF, 128'hF69F2445DF4F9B17AD2B417BE66C3710};
	localparam logic [`WORD_W-1:0] ctA = {128'h601EC313775789A5B7A7F504BBF3D228, 128'hF443E3CA4D62B59ACA84E990CACAF5C5};
	localparam logic [`WORD_W-1:0] ctB = {128'h2B0930DAA23DE94CE87017BA2D84988D, 128'hDFC9C58DB67AADA613C2DD08457941A6};
	localparam logic [`KEY_W-1:0] key2 = 256'h000102030405060708090A0B0C0D0E0F101112131415161718191A1B1C1D1E1F;
	localparam logic [127:0] ct2 = 128'h8EA2B7CA516745BFEAFC49904B496089;

	logic clk;
	logic arst_n;
	logic ce;
	logic holdOff;
	logic [`WORD_W-1:0] counterSeed;
	logic [`KEY_W-1:0] secretKeyIn;
	logic [`WORD_W-1:0] messageIn;
	logic inputQualifier;
	logic inputReady;
	logic outputQualifier;
	logic [`WORD_W-1:0] encryptedOut;
	logic resultReady;
	int error_cnt = 0;
	int n_compared = 0;

	always #2.5 clk = ~clk;

	aes256_ctr_pipeline aes256_ctr_pipeline_inst (.clk(clk), .arst_n(arst_n), .ce(ce), .counterSeed(counterSeed),
		.messageIn(messageIn), .secretKeyIn(secretKeyIn), .inputQualifier(inputQualifier), .inputReady(inputReady),
		.outputQualifier(outputQualifier), .encryptedOut(encryptedOut), .resultReady(resultReady));

	kernel_feeder kernel_feeder_inst (.clk(clk), .ce(ce), .holdOff(holdOff), .inputReady(inputReady),
		.outputQualifier(outputQualifier), .encryptedOut(encryptedOut), .inputQualifier(inputQualifier),
		.messageIn(messageIn), .resultReady(resultReady));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	task automatic check(input logic [`WORD_W-1:0] got, input logic [`WORD_W-1:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic drain(input int n);
		int i;
		for (i = 0; i < 2000 && kernel_feeder_inst.rxq.size() < n; i++)
			@(posedge clk);
		#1;
		if (kernel_feeder_inst.rxq.size() < n)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, kernel_feeder_inst.rxq.size(), n);
			finish_test();
		end
	endtask : drain

	// A word that never finds room ends the run as a mismatch
	task automatic send(input logic [`WORD_W-1:0] w, output int t);
		kernel_feeder_inst.push(w, t);
		if (t < 0)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, t, 0);
			finish_test();
		end
	endtask : send

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic tResetState();
		check({254'h0, inputReady, outputQualifier}, 256'h2);
		check(encryptedOut, 256'h0);
		$display("test reset state done");
	endtask : tResetState

	// Two words back to back cover four consecutive counter blocks
	task automatic tVectors();
		int t0, t1, b;
		b = kernel_feeder_inst.rxq.size();
		secretKeyIn = key1;
		counterSeed = {128'h0, seed1};
		send(ptA, t0);
		send(ptB, t1);
		kernel_feeder_inst.idle();
		drain(b + 2);
		check(256'(t1 - t0), 256'h1);
		check(kernel_feeder_inst.rxq[b], ctA);
		check(kernel_feeder_inst.rxq[b + 1], ctB);
		check(256'(kernel_feeder_inst.rxt[b] - t0), 256'h11);
		check(256'(kernel_feeder_inst.rxt[b + 1] - t1), 256'h11);
		$display("test vectors done");
	endtask : tVectors

	// New key and a nonce mask of all ones; counter is 4 here
	task automatic tKeyChange();
		int t, b;
		b = kernel_feeder_inst.rxq.size();
		secretKeyIn = key2;
		counterSeed = {{128{1'b1}}, 128'hFFEEDDCCBBAA998877665544332210FC};
		send(256'h0, t);
		kernel_feeder_inst.idle();
		drain(b + 1);
		check(256'(kernel_feeder_inst.rxq[b][255:128]), 256'(ct2));
		check(256'(kernel_feeder_inst.rxt[b] - t), 256'h11);
		$display("test key change done");
	endtask : tKeyChange

	// Reader stalls until the word path refuses; counter is 6 here
	task automatic tBackpressure();
		int t, n, b;
		logic [`WORD_W-1:0] held;
		b = kernel_feeder_inst.rxq.size();
		holdOff = 1'b1;
		secretKeyIn = key1;
		counterSeed = {128'h0, 128'hF0F1F2F3F4F5F6F7F8F9FAFBFCFDFEF9};
		for (n = 0; n < 80 && inputReady === 1'b1; n++)
			send(n == 0 ? ptA : (n == 1 ? ptB : 256'(n)), t);
		kernel_feeder_inst.idle();
		check(256'(n < 80), 256'h1);
		held = encryptedOut;
		repeat (8) @(posedge clk);
		#1;
		check({255'h0, outputQualifier}, 256'h1);
		check(encryptedOut, held);
		holdOff = 1'b0;
		drain(b + n);
		repeat (20) @(posedge clk);
		#1;
		check(256'(kernel_feeder_inst.rxq.size()), 256'(b + n));
		check(kernel_feeder_inst.rxq[b], ctA);
		check(kernel_feeder_inst.rxq[b + 1], ctB);
		$display("test backpressure done");
	endtask : tBackpressure

	// A frozen enable delays the result by exactly the frozen edges
	task automatic tClockEnable();
		int t, b;
		b = kernel_feeder_inst.rxq.size();
		send(256'hA5, t);
		kernel_feeder_inst.idle();
		repeat (4) @(posedge clk);
		#1;
		ce = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		ce = 1'b1;
		drain(b + 1);
		check(256'(kernel_feeder_inst.rxt[b] - t), 256'h16);
		$display("test clock enable done");
	endtask : tClockEnable

	// Reset with a word in flight: it must vanish and the counter restart
	task automatic tResetMid();
		int t, b;
		send(256'h5A, t);
		kernel_feeder_inst.idle();
		repeat (5) @(posedge clk);
		#1;
		arst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		arst_n = 1'b1;
		b = kernel_feeder_inst.rxq.size();
		repeat (30) @(posedge clk);
		#1;
		check(256'(kernel_feeder_inst.rxq.size()), 256'(b));
		check({255'h0, outputQualifier}, 256'h0);
		tVectors();
		$display("test reset in flight done");
	endtask : tResetMid

	initial
	begin
		clk = 1'b0;
		arst_n = 1'b0;
		ce = 1'b1;
		holdOff = 1'b0;
		counterSeed = '0;
		secretKeyIn = '0;
		repeat (20) @(posedge clk);
		#1;
		tResetState();
		arst_n = 1'b1;
		tVectors();
		tKeyChange();
		tBackpressure();
		tClockEnable();
		tResetMid();
		finish_test();
	end

endmodule : aes256_ctr_pipeline_tb

// ### verification/kernel_feeder.sv
// Purpose: Model of the kernel logic that feeds plaintext words and drains results
// Assumes: Same clock as the cipher; everything driven 1 ns after the rising edge
// Notes: Released data lines show the inverse of the last word, never a stale copy
`timescale 1ns/10ps
`include "aes_ctr_params.svh"

module kernel_feeder
	import aes_ctr_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic ce, // Clock enable seen by the cipher
	input wire logic holdOff, // Stall the reader
	input wire logic inputReady, // Cipher can take a word
	input wire logic outputQualifier, // Result valid
	input wire logic [`WORD_W-1:0] encryptedOut, // Result word
	output logic inputQualifier, // Word valid
	output logic [`WORD_W-1:0] messageIn, // Plaintext word
	output logic resultReady // Reader takes result
);
	int cyc = 0;
	logic [`WORD_W-1:0] rxq[$];
	int rxt[$];

	initial
	begin
		inputQualifier = 1'b0;
		messageIn = '0;
		resultReady = 1'b1;
	end

	// ****************************************
	// Drain side
	// ****************************************
	// Edge index of each take is kept so the bench can judge latency
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (outputQualifier === 1'b1 && resultReady && ce)
		begin
			rxq.push_back(encryptedOut);
			rxt.push_back(cyc);
		end
		#1;
		resultReady = ~holdOff;
	end

	// ****************************************
	// Feed side
	// ****************************************
	// Word stays up until an edge with room; t is -1 if it never went
	task automatic push(input logic [`WORD_W-1:0] w, output int t);
		int n;
		inputQualifier = 1'b1;
		messageIn = w;
		for (n = 0; n < 200 && !(inputReady === 1'b1 && ce === 1'b1); n++)
		begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		t = (n < 200) ? cyc : -1;
		#1;
	endtask : push

	task automatic idle();
		inputQualifier = 1'b0;
		messageIn = ~messageIn;
	endtask : idle

endmodule : kernel_feeder

// ### verilog/aes256_ctr_pipeline.sv
// Purpose: Fully pipelined counter-mode cipher, 256-bit key, two blocks per word
// Assumes: Feeder logic on the same clock; no synchronisers needed
// Notes: Result appears 16 cycles after acceptance unless the reader stalls or ce goes low
`timescale 1ns/10ps
`include "aes_ctr_params.svh"

module aes256_ctr_pipeline
	import aes_ctr_pkg::*;
(
	input wire logic clk, // Clock, 200 MHz
	input wire logic arst_n, // Async reset, active low
	input wire logic ce, // Clock enable, freezes all datapath state when low
	input wire logic [`WORD_W-1:0] counterSeed, // Counter seed
	input wire logic [`WORD_W-1:0] messageIn, // Plaintext word
	input wire logic [`KEY_W-1:0] secretKeyIn, // Cipher key
	input wire logic inputQualifier, // Plaintext word valid
	output logic inputReady, // Word is taken when high
	output logic outputQualifier, // Ciphertext word valid
	output logic [`WORD_W-1:0] encryptedOut, // Ciphertext word
	input wire logic resultReady // Reader takes result
);

	// ****************************************
	// State and wires
	// ****************************************
	topState_t st_q;
	topState_t st_d;
	logic fifoReady;
	logic fifoValid;
	logic [`WORD_W-1:0] fifoData;
	logic adv;
	logic accept;
	logic loadOut;
	logic [`BLK_W-1:0] nonceSum;
	logic [`BLK_W-1:0] ctrHi;
	logic [`BLK_W-1:0] ctrLo;
	logic [`WORD_W-1:0] blkW [`NUM_ROUNDS+1];
	logic [`KEY_W-1:0] keyW [`NUM_ROUNDS+1];
	logic [`WORD_W-1:0] msgW [`NUM_ROUNDS+1];
	logic vldW [`NUM_ROUNDS+1];

	// Whole pipeline stalls as one; bubbles cost no extra logic
	assign adv = ce && fifoReady;
	assign accept = adv && inputQualifier;
	// Output register refills in the cycle it is emptied
	assign loadOut = ce && (!st_q.outVld || resultReady);

	// ****************************************
	// Counter blocks
	// ****************************************
	always_comb
	begin
		nonceSum = counterSeed[`BLK_W-1:0] + st_q.ctr;
		ctrHi = counterSeed[`WORD_W-1:`BLK_W] ^ nonceSum;
		ctrLo = counterSeed[`WORD_W-1:`BLK_W] ^ (nonceSum + 128'h1);
	end

	// ****************************************
	// Entry stage and output register
	// ****************************************
	always_comb
	begin
		st_d = st_q;
		if (adv)
		begin
			st_d.vld = inputQualifier;
			if (accept)
			begin
				// Round-zero key addition folded into entry
				st_d.blk = {ctrHi ^ secretKeyIn[255:128], ctrLo ^ secretKeyIn[255:128]};
				st_d.key = secretKeyIn;
				st_d.msg = messageIn;
				st_d.ctr = st_q.ctr + `CTR_STEP;
			end
			else
			begin
				// Bubbles carry zeros so no secret lingers
				st_d.blk = '0;
				st_d.key = '0;
				st_d.msg = '0;
			end
		end
		if (loadOut)
		begin
			st_d.outVld = fifoValid;
			if (fifoValid)
				st_d.outData = fifoData;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= '0;
			st_q.ctr <= `CTR_RESET;
		end
		else
			st_q <= st_d;
	end

	// ****************************************
	// Round pipeline
	// ****************************************
	assign blkW[0] = st_q.blk;
	assign keyW[0] = st_q.key;
	assign msgW[0] = st_q.msg;
	assign vldW[0] = st_q.vld;

	for (genvar i = 1; i <= `NUM_ROUNDS; i++)
	begin : g_round
		aes_round #(
			.RND(i)
		) u_round (
			.clk(clk),
			.arst_n(arst_n),
			.adv(adv),
			.blkIn(blkW[i-1]),
			.keyIn(keyW[i-1]),
			.msgIn(msgW[i-1]),
			.vldIn(vldW[i-1]),
			.blkOut(blkW[i]),
			.keyOut(keyW[i]),
			.msgOut(msgW[i]),
			.vldOut(vldW[i])
		);
	end

	// ****************************************
	// Result buffer
	// ****************************************
	// Keystream XOR on the push side keeps total latency at sixteen
	sync_fifo #(
		.WIDTH(`WORD_W),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.inValid(vldW[`NUM_ROUNDS]),
		.inData(blkW[`NUM_ROUNDS] ^ msgW[`NUM_ROUNDS]),
		.inReady(fifoReady),
		.outValid(fifoValid),
		.outData(fifoData),
		.outReady(!st_q.outVld || resultReady)
	);

	assign inputReady = fifoReady;
	assign outputQualifier = st_q.outVld;
	assign encryptedOut = st_q.outData;

	// ****************************************
	// Check helpers
	// ****************************************
	logic [4:0] steadyCnt_q;
	logic [4:0] sinceRst_q;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			steadyCnt_q <= 5'h00;
			sinceRst_q <= 5'h00;
		end
		else
		begin
			if (ce && resultReady)
				steadyCnt_q <= (steadyCnt_q == 5'h1F) ? steadyCnt_q : steadyCnt_q + 5'h01;
			else
				steadyCnt_q <= 5'h00;
			if (sinceRst_q != 5'h1F)
				sinceRst_q <= sinceRst_q + 5'h01;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence s_cleanAccept;
		accept && !fifoValid;
	endsequence

	sequence s_steadyDrain;
		steadyCnt_q >= 5'h10;
	endsequence

	// Qualifier set at edge 16 is only sampled at edge 17
	property p_latency;
		@(posedge clk) disable iff (!arst_n)
		s_cleanAccept ##17 s_steadyDrain |-> outputQualifier;
	endproperty
	a_latency: assert property (p_latency) else $error("result not out 16 cycles after accept");

	sequence s_fullRun;
		adv[*7] ##1 adv[*7];
	endsequence

	property p_constTime;
		@(posedge clk) disable iff (!arst_n)
		accept ##1 s_fullRun |=> vldW[`NUM_ROUNDS];
	endproperty
	a_constTime: assert property (p_constTime) else $error("word took a different path length");

	property p_noEarly;
		@(posedge clk) disable iff (!arst_n)
		(sinceRst_q < 5'h10) |-> !outputQualifier;
	endproperty
	a_noEarly: assert property (p_noEarly) else $error("qualifier before pipeline could fill");

	property p_ctrStep;
		@(posedge clk) disable iff (!arst_n)
		accept |=> st_q.ctr == $past(st_q.ctr) + `CTR_STEP;
	endproperty
	a_ctrStep: assert property (p_ctrStep) else $error("counter did not step by two blocks");

	property p_ctrHold;
		@(posedge clk) disable iff (!arst_n)
		!accept |=> $stable(st_q.ctr);
	endproperty
	a_ctrHold: assert property (p_ctrHold) else $error("counter moved without a block");

	property p_outHold;
		@(posedge clk) disable iff (!arst_n)
		outputQualifier && !resultReady |=> outputQualifier && $stable(encryptedOut);
	endproperty
	a_outHold: assert property (p_outHold) else $error("result dropped while reader stalled");

	property p_freeze;
		@(posedge clk) disable iff (!arst_n)
		!ce |=> $stable(st_q) && $stable(inputReady);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

	property p_bubbleClean;
		@(posedge clk) disable iff (!arst_n)
		adv && !inputQualifier |=> !st_q.vld && (st_q.key == '0) && (st_q.msg == '0);
	endproperty
	a_bubbleClean: assert property (p_bubbleClean) else $error("bubble kept secret data");

	property p_keyEntry;
		@(posedge clk) disable iff (!arst_n)
		accept |=> st_q.vld && (st_q.key == $past(secretKeyIn)) && (st_q.msg == $past(messageIn));
	endproperty
	a_keyEntry: assert property (p_keyEntry) else $error("entry stage missed key or data");

	property p_outSource;
		@(posedge clk) disable iff (!arst_n)
		$past(loadOut) && $past(fifoValid) |-> outputQualifier && (encryptedOut == $past(fifoData));
	endproperty
	a_outSource: assert property (p_outSource) else $error("output register missed buffered result");

	// ****************************************
	// Stall, drain and counter-block checks
	// ****************************************
	property p_outDrop;
		@(posedge clk) disable iff (!arst_n)
		outputQualifier && resultReady && ce && !fifoValid |=> !outputQualifier;
	endproperty
	a_outDrop: assert property (p_outDrop) else $error("qualifier stayed up with nothing new");

	property p_halves;
		@(posedge clk) disable iff (!arst_n)
		accept |=> st_q.blk[255:128] != st_q.blk[127:0];
	endproperty
	a_halves: assert property (p_halves) else $error("both halves used one counter block");

	// A full buffer must freeze the last stage, or a result is lost
	property p_pipeHold;
		@(posedge clk) disable iff (!arst_n)
		vldW[`NUM_ROUNDS] && !inputReady |=> vldW[`NUM_ROUNDS];
	endproperty
	a_pipeHold: assert property (p_pipeHold) else $error("last stage dropped a word while full");

	property p_readyBack;
		@(posedge clk) disable iff (!arst_n)
		!inputReady && outputQualifier && resultReady && ce |=> inputReady;
	endproperty
	a_readyBack: assert property (p_readyBack) else $error("ready did not return after a take");

	property p_refuse;
		@(posedge clk) disable iff (!arst_n)
		!inputReady |=> $stable(st_q.ctr) && $stable(st_q.key);
	endproperty
	a_refuse: assert property (p_refuse) else $error("word taken while buffer full");

endmodule : aes256_ctr_pipeline

// ### verilog/aes_ctr_params.svh
// Purpose: Shared constants for the counter-mode cipher pipeline
// Assumes: Included by bare name
// Notes: Widths and depths are fixed
`ifndef AES_CTR_PARAMS_SVH
`define AES_CTR_PARAMS_SVH

`define WORD_W 256
`define BLK_W 128
`define KEY_W 256
`define CTR_W 128
`define NUM_ROUNDS 14
`define PIPE_LATENCY 16
`define FIFO_DEPTH 16
`define CTR_RESET 128'h0
`define CTR_STEP 128'h2
`define AFFINE_C 8'h63
`define CLK_PERIOD_PS 5000

`endif

// ### verilog/aes_ctr_pkg.sv
// Purpose: Types and byte-level cipher functions
// Assumes: aes_ctr_params.svh constants
// Notes: S-box is computed, not tabled, to avoid a memory image
`include "aes_ctr_params.svh"

package aes_ctr_pkg;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [`WORD_W-1:0] blk;
		logic [`KEY_W-1:0] key;
		logic [`WORD_W-1:0] msg;
		logic vld;
	} roundState_t;

	typedef struct packed {
		logic [`CTR_W-1:0] ctr;
		logic [`WORD_W-1:0] blk;
		logic [`KEY_W-1:0] key;
		logic [`WORD_W-1:0] msg;
		logic vld;
		logic outVld;
		logic [`WORD_W-1:0] outData;
	} topState_t;

	// ****************************************
	// Field arithmetic
	// ****************************************
	function automatic logic [7:0] xtime(input logic [7:0] a);
		xtime = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
	endfunction : xtime

	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] r;
		logic [7:0] x;
		r = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++)
		begin
			if (b[i])
				r = r ^ x;
			x = xtime(x);
		end
		gmul = r;
	endfunction : gmul

	// Inverse as x^254, then the affine map
	function automatic logic [7:0] sbox(input logic [7:0] a);
		logic [7:0] r;
		logic [7:0] y;
		r = 8'h01;
		y = a;
		for (int i = 0; i < 8; i++)
		begin
			if (i != 0)
				r = gmul(r, y);
			y = gmul(y, y);
		end
		sbox = r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]} ^ `AFFINE_C;
	endfunction : sbox

	function automatic logic [31:0] subWord(input logic [31:0] w);
		subWord = {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
	endfunction : subWord

	function automatic logic [7:0] rcon(input int idx);
		logic [7:0] r;
		r = 8'h01;
		for (int i = 1; i < 8; i++)
		begin
			if (i < idx)
				r = xtime(r);
		end
		rcon = r;
	endfunction : rcon

	// Substitute, shift rows, optionally mix columns
	function automatic logic [`BLK_W-1:0] roundCore(input logic [`BLK_W-1:0] s, input logic last);
		logic [15:0][7:0] sb;
		logic [15:0][7:0] sr;
		logic [`BLK_W-1:0] o;
		logic [7:0] a0, a1, a2, a3;
		o = '0;
		for (int n = 0; n < 16; n++)
			sb[n] = sbox(s[127-8*n -: 8]);
		for (int c = 0; c < 4; c++)
			for (int r = 0; r < 4; r++)
				sr[4*c+r] = sb[4*((c+r)%4)+r];
		for (int c = 0; c < 4; c++)
		begin
			a0 = sr[4*c];
			a1 = sr[4*c+1];
			a2 = sr[4*c+2];
			a3 = sr[4*c+3];
			if (last)
				o[127-32*c -: 32] = {a0, a1, a2, a3};
			else
				o[127-32*c -: 32] = {xtime(a0) ^ xtime(a1) ^ a1 ^ a2 ^ a3,
					a0 ^ xtime(a1) ^ xtime(a2) ^ a2 ^ a3,
					a0 ^ a1 ^ xtime(a2) ^ xtime(a3) ^ a3,
					xtime(a0) ^ a0 ^ a1 ^ a2 ^ xtime(a3)};
		end
		roundCore = o;
	endfunction : roundCore

endpackage : aes_ctr_pkg

// ### verilog/aes_round.sv
// Purpose: One registered cipher round for two blocks plus one key-schedule step
// Assumes: Previous stage has already added its round key
// Notes: Data moves only when adv is high
`timescale 1ns/10ps
`include "aes_ctr_params.svh"

module aes_round
	import aes_ctr_pkg::*;
#(
	parameter int RND = 1
)
(
	input wire logic clk, // Clock
	input wire logic arst_n, // Async reset, active low
	input wire logic adv, // Pipeline advance
	input wire logic [`WORD_W-1:0] blkIn, // Two cipher states
	input wire logic [`KEY_W-1:0] keyIn, // Key window of previous round
	input wire logic [`WORD_W-1:0] msgIn, // Plaintext riding along
	input wire logic vldIn, // Stage holds a word
	output logic [`WORD_W-1:0] blkOut, // Two cipher states
	output logic [`KEY_W-1:0] keyOut, // Next key window
	output logic [`WORD_W-1:0] msgOut, // Plaintext riding along
	output logic vldOut // Stage holds a word
);

	roundState_t st_q;
	roundState_t st_d;
	logic [`BLK_W-1:0] rk;
	logic [31:0] t;
	logic [31:0] n0, n1, n2, n3;

	// ****************************************
	// Round and schedule
	// ****************************************
	always_comb
	begin
		rk = keyIn[`BLK_W-1:0];
		if (RND % 2 == 1)
			t = subWord({keyIn[23:0], keyIn[31:24]}) ^ {rcon((RND + 1) / 2), 24'h000000};
		else
			t = subWord(keyIn[31:0]);
		n0 = keyIn[255:224] ^ t;
		n1 = keyIn[223:192] ^ n0;
		n2 = keyIn[191:160] ^ n1;
		n3 = keyIn[159:128] ^ n2;
		st_d = st_q;
		if (adv)
		begin
			st_d.blk[255:128] = roundCore(blkIn[255:128], RND == `NUM_ROUNDS) ^ rk;
			st_d.blk[127:0] = roundCore(blkIn[127:0], RND == `NUM_ROUNDS) ^ rk;
			st_d.key = {keyIn[127:0], n0, n1, n2, n3};
			st_d.msg = msgIn;
			st_d.vld = vldIn;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign blkOut = st_q.blk;
	assign keyOut = st_q.key;
	assign msgOut = st_q.msg;
	assign vldOut = st_q.vld;

	// ****************************************
	// Checks
	// ****************************************
	property p_roundAdvance;
		@(posedge clk) disable iff (!arst_n)
		adv |=> (vldOut == $past(vldIn)) && (msgOut == $past(msgIn));
	endproperty
	a_roundAdvance: assert property (p_roundAdvance) else $error("round stage did not advance");

	property p_roundHold;
		@(posedge clk) disable iff (!arst_n)
		!adv |=> $stable(blkOut) && $stable(keyOut) && $stable(vldOut);
	endproperty
	a_roundHold: assert property (p_roundHold) else $error("round stage moved while stalled");

endmodule : aes_round

// ### verilog/sync_fifo.sv
// Purpose: Result buffer between cipher pipeline and output register
// Assumes: Single clock, writes only when inReady
// Notes: inReady is a flop so stall never depends on the reader combinationally
`timescale 1ns/10ps

module sync_fifo
#(
	parameter int WIDTH = 256,
	parameter int DEPTH = 16
)
(
	input wire logic clk, // Clock
	input wire logic arst_n, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic inValid, // Write request
	input wire logic [WIDTH-1:0] inData, // Write data
	output logic inReady, // Room for a word
	output logic outValid, // Word available
	output logic [WIDTH-1:0] outData, // Head word
	input wire logic outReady // Reader takes head
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0] count;
		logic notFull;
	} fifoState_t;

	fifoState_t st_q;
	fifoState_t st_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	assign push = ce && inValid && st_q.notFull;
	assign pop = ce && outValid && outReady;

	always_comb
	begin
		st_d = st_q;
		if (push)
			st_d.wrPtr = st_q.wrPtr + 1'b1;
		if (pop)
			st_d.rdPtr = st_q.rdPtr + 1'b1;
		if (push && !pop)
			st_d.count = st_q.count + 1'b1;
		else if (pop && !push)
			st_d.count = st_q.count - 1'b1;
		st_d.notFull = (st_d.count != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			st_q <= '{wrPtr: '0, rdPtr: '0, count: '0, notFull: 1'b1};
		else
			st_q <= st_d;
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem[st_q.wrPtr] <= inData;
	end

	assign inReady = st_q.notFull;
	assign outValid = (st_q.count != '0);
	assign outData = mem[st_q.rdPtr];

	property p_fifoCount;
		@(posedge clk) disable iff (!arst_n)
		(push && !pop) |=> (st_q.count == $past(st_q.count) + 1'b1);
	endproperty
	a_fifoCount: assert property (p_fifoCount) else $error("fifo count did not rise on push");

	property p_fifoFull;
		@(posedge clk) disable iff (!arst_n)
		!inReady |-> (st_q.count == (AW+1)'(DEPTH));
	endproperty
	a_fifoFull: assert property (p_fifoFull) else $error("fifo refused while not full");

endmodule : sync_fifo
